// ### rtl/cad_regs.svh
// register offsets, field positions, reset values and timing counts of the datapath
// assumes a core clock of 125 MHz and a decoder that serialises all operations
//
// Contract
// [RQ1] integer alu is 16 bits: add, subtract, shifts, logic, two's complement
// [RQ2] alu updates carry, zero, negative, overflow and nibble carry flags per operation
// [RQ3] on subtraction carry means no borrow and nibble carry means no digit borrow
// [RQ4] byte or word operation chosen by the instruction size mode
// [RQ5] operands from working registers or memory; result may go to either
// [RQ6] 17x17 multiplier: 16x16 all sign mixes, 16 by 5-bit literal, 8x8 unsigned
// [RQ7] divider does 32/16 and 16/16, both signed or both unsigned
// [RQ8] quotient goes to working register zero, remainder to working register one
// [RQ9] divisor any register; 32-bit dividend an aligned pair, odd holds upper half
// [RQ10] divide takes one cycle per divisor bit, same count for both forms
// [RQ11] dsp engine: 17x17 multiplier, shifter, 40-bit adder, two accumulators
// [RQ12] dsp never runs beside another operation; one instruction may use both
// [RQ13] accumulator add, subtract and negate need no data operands
// [RQ14] control selects fractional/integer, signed/unsigned, conventional/convergent rounding
// [RQ15] separate clamp enables for accumulator a, b and memory writes; clamp width
// [RQ16] dsp operation set; write back only for clear, mac, prefetch, multiply-subtract
// [RQ17] file direct uses instruction address; register direct uses register contents
// [RQ18] indirect uses pointer as address; post-modified then steps the pointer
// [RQ19] pre-modified first steps pointer by signed constant, then uses it
// [RQ20] indexed adds pointer and offset register; literal offset adds a literal
// [RQ21] enabled clamping limits results to most positive or negative of the width
// [RQ22] prefetch pointers limited to four registers, two for x, two for y
`ifndef CAD_REGS_SVH
`define CAD_REGS_SVH

`define CAD_OFF_CTRL      4'h0
`define CAD_OFF_FLAGS     4'h1
`define CAD_OFF_ACCUM_A_LO   4'h2
`define CAD_OFF_ACCUM_A_MID  4'h3
`define CAD_OFF_ACCUM_A_HI   4'h4
`define CAD_OFF_ACCUM_B_LO   4'h5
`define CAD_OFF_ACCUM_B_MID  4'h6
`define CAD_OFF_ACCUM_B_HI   4'h7

// core_control_reg fields
`define CAD_CTL_INT_MUL   0
`define CAD_CTL_SIGN_MODE 1
`define CAD_CTL_ROUND     2
`define CAD_CTL_CLAMP_A   3
`define CAD_CTL_CLAMP_B   4
`define CAD_CTL_CLAMP_MEM 5
`define CAD_CTL_WIDTH     6
`define CAD_CTL_RESET     7'h00

// core_flag_register fields
`define CAD_FLG_C         0
`define CAD_FLG_Z         1
`define CAD_FLG_N         2
`define CAD_FLG_V         3
`define CAD_FLG_NIB       4
`define CAD_FLG_RESET     5'h00

`define CAD_DIV_STEPS     5'h10
`define CAD_QUOT_WREG     4'h0
`define CAD_REM_WREG      4'h1
`define CAD_XPF_BASE      4'h8
`define CAD_YPF_BASE      4'ha

`endif

// ### rtl/cad_pkg.sv
// operation, multiply-mode and addressing-mode types of the datapath
// assumes the decoder drives these codes directly
package cad_pkg;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR,
    OP_SHL, OP_LSR, OP_ASR, OP_MUL, OP_DIV,
    ACC_CLEAR_OP, SQ_DISTANCE_OP, SQ_DISTANCE_ACCUM_OP, OP_MAC, OP_SQ_ACC,
    PRODUCT_LOAD_OP, OP_SQ_LOAD, NEG_PRODUCT_LOAD_OP, PRODUCT_SUBTRACT_OP,
    PREFETCH_STORE_OP, OP_ACC_ADD, OP_ACC_SUB, OP_ACC_NEG
  } cad_op_e;

  typedef enum logic [2:0] {
    MUL_SGN_SGN, MUL_UNS_UNS, MUL_SGN_UNS, MUL_UNS_SGN,
    MUL_SGN_LIT, MUL_UNS_LIT, MUL_BYTE
  } cad_mul_e;

  typedef enum logic [2:0] {
    EA_FILE_DIRECT, EA_REG_DIRECT, EA_INDIRECT, EA_POST_MOD,
    EA_PRE_MOD, EA_INDEXED, EA_LIT_OFFSET
  } cad_ea_e;

endpackage : cad_pkg

// ### rtl/cad_datapath.sv
// integer alu, multiplier, divider, dsp engine and address unit of the core
// assumes the decoder holds operands steady in the cycle it raises op_valid
`include "cad_regs.svh"

module cad_datapath import cad_pkg::*; (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        op_valid,
  input  wire cad_op_e     op_code,
  input  wire logic        op_byte,
  input  wire logic        op_dst_mem,
  input  wire logic [3:0]  op_dst_reg,
  input  wire cad_mul_e    mul_mode,
  input  wire logic        div_signed,
  input  wire logic        div_long,
  input  wire logic [15:0] op_a,
  input  wire logic [15:0] op_b,
  input  wire logic [15:0] op_hi,
  input  wire logic [4:0]  op_lit,
  input  wire logic        op_acc_b,
  input  wire logic        pf_x_sel,
  input  wire logic        pf_y_sel,
  output logic             op_ready,
  output logic             res_valid_q,
  output logic      [15:0] res_data_q,
  output logic      [15:0] res_hi_q,
  output logic             res_to_mem_q,
  output logic      [3:0]  res_wreg_lo_q,
  output logic      [3:0]  res_wreg_hi_q,
  output logic             acc_wb_valid_q,
  output logic      [15:0] acc_wb_data_q,
  output logic      [3:0]  pf_x_reg_q,
  output logic      [3:0]  pf_y_reg_q,
  output logic      [4:0]  core_flag_register,
  input  wire logic        ea_valid,
  input  wire cad_ea_e     ea_mode,
  input  wire logic [15:0] ea_ptr,
  input  wire logic [15:0] ea_offset,
  input  wire logic [15:0] ea_lit,
  output logic             ea_valid_q,
  output logic      [15:0] ea_q,
  output logic      [15:0] ea_ptr_new_q,
  output logic             ea_ptr_wr_q
);

  logic [6:0]  core_control_reg;
  logic [39:0] accum_a, accum_b;
  logic        div_busy_q, div_fin_q, div_neg_q_q, div_neg_r_q;
  logic [4:0]  div_cnt_q;
  logic [15:0] div_rem_q, div_quo_q, div_den_q;

  wire op_go     = op_valid && op_ready;
  wire is_arith  = op_code inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB};
  wire is_logic  = op_code inside {OP_AND, OP_IOR, OP_XOR, OP_SHL, OP_LSR, OP_ASR};
  wire is_dsp    = op_code >= ACC_CLEAR_OP;
  wire is_sqdist = op_code inside {SQ_DISTANCE_OP, SQ_DISTANCE_ACCUM_OP};
  wire is_square = op_code inside {OP_SQ_ACC, OP_SQ_LOAD};

  // [RQ12] one operation at a time
  assign op_ready = !div_busy_q && !div_fin_q;

  wire mode_int    = core_control_reg[`CAD_CTL_INT_MUL];
  wire mode_uns    = core_control_reg[`CAD_CTL_SIGN_MODE];
  wire round_conv  = core_control_reg[`CAD_CTL_ROUND];
  wire clamp_a     = core_control_reg[`CAD_CTL_CLAMP_A];
  wire clamp_b     = core_control_reg[`CAD_CTL_CLAMP_B];
  wire clamp_mem   = core_control_reg[`CAD_CTL_CLAMP_MEM];
  wire clamp_wide  = core_control_reg[`CAD_CTL_WIDTH];

  // [RQ1] [RQ3] subtraction adds the inverted operand, so carry reads as no-borrow
  wire         is_sub  = op_code inside {OP_SUB, OP_SUBB};
  wire [15:0]  b_in    = is_sub ? ~op_b : op_b;
  wire         cin     = (op_code == OP_SUB) ? 1'b1 :
                         (op_code inside {OP_ADDC, OP_SUBB}) ? core_flag_register[`CAD_FLG_C]
                                                             : 1'b0;
  wire [16:0]  sum16   = {1'b0, op_a} + {1'b0, b_in} + {16'h0000, cin};
  wire [8:0]   sum8    = {1'b0, op_a[7:0]} + {1'b0, b_in[7:0]} + {8'h00, cin};
  wire [4:0]   sum4    = {1'b0, op_a[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin};
  wire [3:0]   sh      = op_lit[3:0];
  wire [15:0]  a_zx    = op_byte ? {8'h00, op_a[7:0]} : op_a;
  wire [15:0]  a_sx    = op_byte ? {{8{op_a[7]}}, op_a[7:0]} : op_a;

  logic [15:0] alu_r;
  always_comb begin
    unique case (op_code)
      OP_AND:  alu_r = op_a & op_b;
      OP_IOR:  alu_r = op_a | op_b;
      OP_XOR:  alu_r = op_a ^ op_b;
      OP_SHL:  alu_r = op_a << sh;
      OP_LSR:  alu_r = a_zx >> sh;
      OP_ASR:  alu_r = 16'($signed(a_sx) >>> sh);
      default: alu_r = sum16[15:0];
    endcase
  end

  // [RQ4] byte mode flags look at the low byte only
  wire [15:0] alu_out  = op_byte ? {8'h00, alu_r[7:0]} : alu_r;
  wire        r_msb    = op_byte ? alu_r[7] : alu_r[15];
  wire        a_msb    = op_byte ? op_a[7] : op_a[15];
  wire        b_msb    = op_byte ? b_in[7] : b_in[15];
  wire        r_zero   = op_byte ? (alu_r[7:0] == 8'h00) : (alu_r == 16'h0000);
  wire        c_out    = op_byte ? sum8[8] : sum16[16];
  wire        v_out    = (a_msb == b_msb) && (r_msb != a_msb);

  // shared 17x17 signed multiplier; operands widened per mode
  logic [16:0] mx, my;
  wire  [16:0] dx  = mode_uns ? {1'b0, op_a} : {op_a[15], op_a};
  wire  [16:0] dy  = mode_uns ? {1'b0, op_b} : {op_b[15], op_b};
  wire  [16:0] dd  = dx - dy;
  always_comb begin
    mx = {op_a[15], op_a};
    my = {op_b[15], op_b};
    if (is_sqdist) begin
      // [RQ12] operand difference dd feeds the dsp multiplier in one instruction
      mx = dd;
      my = dd;
    end else if (is_square) begin
      mx = dx;
      my = dx;
    end else if (is_dsp) begin
      mx = dx;
      my = dy;
    end else begin
      // [RQ6] integer multiply operand widening
      unique case (mul_mode)
        MUL_SGN_SGN: begin mx = {op_a[15], op_a}; my = {op_b[15], op_b}; end
        MUL_UNS_UNS: begin mx = {1'b0, op_a};     my = {1'b0, op_b};     end
        MUL_SGN_UNS: begin mx = {op_a[15], op_a}; my = {1'b0, op_b};     end
        MUL_UNS_SGN: begin mx = {1'b0, op_a};     my = {op_b[15], op_b}; end
        MUL_SGN_LIT: begin mx = {op_a[15], op_a}; my = {12'h000, op_lit}; end
        MUL_UNS_LIT: begin mx = {1'b0, op_a};     my = {12'h000, op_lit}; end
        MUL_BYTE:    begin mx = {9'h000, op_a[7:0]}; my = {9'h000, op_b[7:0]}; end
        default:     begin mx = 17'h00000; my = 17'h00000; end
      endcase
    end
  end
  // [RQ11] 17x17 multiplier
  wire [33:0] mul_p = 34'($signed(mx) * $signed(my));

  // [RQ14] fractional products are shifted left one place
  wire [34:0] prod_sh  = mode_int ? {mul_p[33], mul_p} : {mul_p, 1'b0};
  wire [40:0] prod     = {{6{prod_sh[34]}}, prod_sh};
  wire [39:0] acc_tgt  = op_acc_b ? accum_b : accum_a;
  wire [39:0] acc_oth  = op_acc_b ? accum_a : accum_b;
  wire [40:0] tgt_x    = {acc_tgt[39], acc_tgt};
  wire [40:0] oth_x    = {acc_oth[39], acc_oth};

  // [RQ16] [RQ13] 40-bit adder, one guard bit to detect overflow
  logic [40:0] dsp_sum;
  always_comb begin
    unique case (op_code)
      ACC_CLEAR_OP:                         dsp_sum = 41'h0;
      SQ_DISTANCE_OP, PRODUCT_LOAD_OP,
      OP_SQ_LOAD:                           dsp_sum = prod;
      SQ_DISTANCE_ACCUM_OP, OP_MAC,
      OP_SQ_ACC:                            dsp_sum = tgt_x + prod;
      NEG_PRODUCT_LOAD_OP:                  dsp_sum = 41'h0 - prod;
      PRODUCT_SUBTRACT_OP:                  dsp_sum = tgt_x - prod;
      OP_ACC_ADD:                           dsp_sum = tgt_x + oth_x;
      OP_ACC_SUB:                           dsp_sum = tgt_x - oth_x;
      OP_ACC_NEG:                           dsp_sum = 41'h0 - tgt_x;
      default:                              dsp_sum = tgt_x;
    endcase
  end

  // [RQ21] clamp to the narrow 32-bit or full 40-bit range
  function automatic logic [39:0] clamp40(input logic [40:0] s, input logic en,
                                          input logic wide);
    logic ovf;
    ovf = wide ? (s[40] != s[39]) : !(s[40:31] == 10'h000 || s[40:31] == 10'h3ff);
    if (!en || !ovf)
      return s[39:0];
    if (wide)
      return s[40] ? 40'h8000000000 : 40'h7fffffffff;
    return s[40] ? 40'hff80000000 : 40'h007fffffff;
  endfunction : clamp40

  // [RQ15] per-accumulator clamp enable
  wire [39:0] acc_new = clamp40(dsp_sum, op_acc_b ? clamp_b : clamp_a, clamp_wide);

  // [RQ14] convergent rounding leaves an exact half on an even result
  wire        add_half = round_conv || (acc_oth[15:0] != 16'h8000) || acc_oth[16];
  wire [40:0] rnd      = oth_x + (add_half ? 41'h0000008000 : 41'h0);
  wire        rnd_ovf  = !(rnd[40:31] == 10'h000 || rnd[40:31] == 10'h3ff);
  // [RQ15] memory write clamp
  wire [15:0] wb_word  = (clamp_mem && rnd_ovf) ? (rnd[40] ? 16'h8000 : 16'h7fff)
                                                : rnd[31:16];
  // [RQ16] write back of the other accumulator
  wire        wb_op    = op_code inside {ACC_CLEAR_OP, OP_MAC, PREFETCH_STORE_OP,
                                         PRODUCT_SUBTRACT_OP};

  // [RQ2] flags set by hardware win over a software write in the same cycle
  logic [4:0] flags_d;
  always_comb begin
    flags_d = core_flag_register;
    if (reg_wr && reg_addr == `CAD_OFF_FLAGS)
      flags_d = reg_wdata[4:0];
    if (op_go && (is_arith || is_logic)) begin
      flags_d[`CAD_FLG_Z] = r_zero;
      flags_d[`CAD_FLG_N] = r_msb;
    end
    if (op_go && is_arith) begin
      // [RQ3] carry and nibble carry are no-borrow flags on subtraction
      flags_d[`CAD_FLG_C]   = c_out;
      flags_d[`CAD_FLG_V]   = v_out;
      flags_d[`CAD_FLG_NIB] = sum4[4];
    end
  end

  // [RQ7] [RQ9] magnitudes; odd register of the pair arrives as op_hi
  wire        dvd_neg  = div_signed && (div_long ? op_hi[15] : op_a[15]);
  wire        dvs_neg  = div_signed && op_b[15];
  wire [31:0] dvd_raw  = div_long ? {op_hi, op_a} : {{16{div_signed & op_a[15]}}, op_a};
  wire [31:0] dvd_mag  = dvd_neg ? 32'h0 - dvd_raw : dvd_raw;
  wire [15:0] dvs_mag  = dvs_neg ? 16'h0 - op_b : op_b;
  wire [16:0] rem_sh   = {div_rem_q, div_quo_q[15]};
  wire [16:0] rem_try  = rem_sh - {1'b0, div_den_q};
  wire        rem_fits = !rem_try[16];

  // [RQ10] one restoring step per divisor bit, both forms alike
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_busy_q  <= 1'b0;
      div_fin_q   <= 1'b0;
      div_cnt_q   <= 5'h00;
      div_rem_q   <= 16'h0000;
      div_quo_q   <= 16'h0000;
      div_den_q   <= 16'h0000;
      div_neg_q_q <= 1'b0;
      div_neg_r_q <= 1'b0;
    end else if (op_go && op_code == OP_DIV) begin
      div_busy_q  <= 1'b1;
      div_cnt_q   <= 5'h00;
      div_rem_q   <= dvd_mag[31:16];
      div_quo_q   <= dvd_mag[15:0];
      div_den_q   <= dvs_mag;
      div_neg_q_q <= dvd_neg ^ dvs_neg;
      div_neg_r_q <= dvd_neg;
    end else if (div_busy_q) begin
      div_rem_q  <= rem_fits ? rem_try[15:0] : rem_sh[15:0];
      div_quo_q  <= {div_quo_q[14:0], rem_fits};
      div_cnt_q  <= div_cnt_q + 5'h01;
      div_busy_q <= (div_cnt_q != `CAD_DIV_STEPS - 5'h01);
      div_fin_q  <= (div_cnt_q == `CAD_DIV_STEPS - 5'h01);
    end else begin
      div_fin_q <= 1'b0;
    end
  end

  // results of alu, multiply and divide
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      res_valid_q   <= 1'b0;
      res_data_q    <= 16'h0000;
      res_hi_q      <= 16'h0000;
      res_to_mem_q  <= 1'b0;
      res_wreg_lo_q <= 4'h0;
      res_wreg_hi_q <= 4'h0;
    end else if (div_fin_q) begin
      // [RQ8] quotient to register zero, remainder to register one
      res_valid_q   <= 1'b1;
      res_data_q    <= div_neg_q_q ? 16'h0 - div_quo_q : div_quo_q;
      res_hi_q      <= div_neg_r_q ? 16'h0 - div_rem_q : div_rem_q;
      res_to_mem_q  <= 1'b0;
      res_wreg_lo_q <= `CAD_QUOT_WREG;
      res_wreg_hi_q <= `CAD_REM_WREG;
    end else begin
      res_valid_q   <= op_go && (is_arith || is_logic || op_code == OP_MUL);
      // [RQ5] destination kind travels with the result
      res_to_mem_q  <= op_dst_mem;
      res_wreg_lo_q <= op_dst_reg;
      res_wreg_hi_q <= op_dst_reg | 4'h1;
      res_data_q    <= (op_code == OP_MUL) ? mul_p[15:0] : alu_out;
      res_hi_q      <= (op_code == OP_MUL) ? mul_p[31:16] : 16'h0000;
    end
  end

  // accumulators, write back and prefetch pointer selection
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      accum_a        <= 40'h0;
      accum_b        <= 40'h0;
      acc_wb_valid_q <= 1'b0;
      acc_wb_data_q  <= 16'h0000;
      pf_x_reg_q     <= `CAD_XPF_BASE;
      pf_y_reg_q     <= `CAD_YPF_BASE;
    end else begin
      acc_wb_valid_q <= op_go && is_dsp && wb_op;
      if (op_go && is_dsp) begin
        if (op_code != PREFETCH_STORE_OP && !op_acc_b)
          accum_a <= acc_new;
        if (op_code != PREFETCH_STORE_OP && op_acc_b)
          accum_b <= acc_new;
        acc_wb_data_q <= wb_word;
        // [RQ22] prefetch pointers limited to two x and two y registers
        pf_x_reg_q    <= `CAD_XPF_BASE | {3'b000, pf_x_sel};
        pf_y_reg_q    <= `CAD_YPF_BASE | {3'b000, pf_y_sel};
      end
    end
  end

  // effective address unit
  logic [15:0] ea_d, ptr_d;
  logic        ptr_wr_d;
  always_comb begin
    ea_d     = ea_ptr;
    ptr_d    = ea_ptr;
    ptr_wr_d = 1'b0;
    unique case (ea_mode)
      // [RQ17] explicit address or register contents
      EA_FILE_DIRECT: ea_d = ea_lit;
      EA_REG_DIRECT:  ea_d = ea_ptr;
      // [RQ18] pointer used as address; post-modified mode then steps it
      EA_INDIRECT:    ea_d = ea_ptr;
      EA_POST_MOD: begin
        ptr_d    = ea_ptr + ea_lit;
        ptr_wr_d = 1'b1;
      end
      // [RQ19] pointer stepped, then used
      EA_PRE_MOD: begin
        ea_d     = ea_ptr + ea_lit;
        ptr_d    = ea_ptr + ea_lit;
        ptr_wr_d = 1'b1;
      end
      // [RQ20] base plus offset register or literal
      EA_INDEXED:     ea_d = ea_ptr + ea_offset;
      EA_LIT_OFFSET:  ea_d = ea_ptr + ea_lit;
      default:        ea_d = ea_ptr;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ea_valid_q   <= 1'b0;
      ea_q         <= 16'h0000;
      ea_ptr_new_q <= 16'h0000;
      ea_ptr_wr_q  <= 1'b0;
    end else begin
      ea_valid_q   <= ea_valid;
      ea_ptr_wr_q  <= ea_valid && ptr_wr_d;
      ea_q         <= ea_d;
      ea_ptr_new_q <= ptr_d;
    end
  end

  // register port; unmapped reads return zero
  wire [15:0] rd_mux =
    (reg_addr == `CAD_OFF_CTRL)     ? {9'h000, core_control_reg} :
    (reg_addr == `CAD_OFF_FLAGS)    ? {11'h000, core_flag_register} :
    (reg_addr == `CAD_OFF_ACCUM_A_LO)  ? accum_a[15:0] :
    (reg_addr == `CAD_OFF_ACCUM_A_MID) ? accum_a[31:16] :
    (reg_addr == `CAD_OFF_ACCUM_A_HI)  ? {8'h00, accum_a[39:32]} :
    (reg_addr == `CAD_OFF_ACCUM_B_LO)  ? accum_b[15:0] :
    (reg_addr == `CAD_OFF_ACCUM_B_MID) ? accum_b[31:16] :
    (reg_addr == `CAD_OFF_ACCUM_B_HI)  ? {8'h00, accum_b[39:32]} : 16'h0000;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      core_control_reg   <= `CAD_CTL_RESET;
      core_flag_register <= `CAD_FLG_RESET;
      reg_rdata          <= 16'h0000;
    end else begin
      core_flag_register <= flags_d;
      reg_rdata          <= reg_rd ? rd_mux : 16'h0000;
      if (reg_wr && reg_addr == `CAD_OFF_CTRL)
        core_control_reg <= reg_wdata[6:0];
    end
  end

  // checks
  property p_div_result;
    @(posedge clock) disable iff (!resetn)
      (op_go && op_code == OP_DIV) |-> ##18 (res_valid_q && res_wreg_lo_q == 4'h0
                                             && res_wreg_hi_q == 4'h1);
  endproperty
  a_div_result: assert property (p_div_result) else $error("divide result late or misrouted"); // [RQ8]

  property p_div_hold;
    @(posedge clock) disable iff (!resetn)
      (op_go && op_code == OP_DIV) |=> !op_ready [*8];
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("ready during divide"); // [RQ10]

  property p_zero_flag;
    @(posedge clock) disable iff (!resetn)
      $past(op_go && is_arith && !op_byte) |->
        core_flag_register[`CAD_FLG_Z] == (res_data_q == 16'h0000);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag mismatch"); // [RQ2]

  property p_borrow;
    @(posedge clock) disable iff (!resetn)
      (op_go && op_code == OP_SUB && !op_byte) |=>
        core_flag_register[`CAD_FLG_C] == ($past(op_a) >= $past(op_b));
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow flag wrong"); // [RQ3]

  property p_mul_uu;
    @(posedge clock) disable iff (!resetn)
      (op_go && op_code == OP_MUL && mul_mode == MUL_UNS_UNS) |=>
        {res_hi_q, res_data_q} == {16'h0000, $past(op_a)} * {16'h0000, $past(op_b)};
  endproperty
  a_mul_uu: assert property (p_mul_uu) else $error("unsigned product wrong"); // [RQ6]

  property p_pre_mod;
    @(posedge clock) disable iff (!resetn)
      (ea_valid && ea_mode == EA_PRE_MOD) |=>
        (ea_q == 16'($past(ea_ptr) + $past(ea_lit)) && ea_ptr_new_q == ea_q && ea_ptr_wr_q);
  endproperty
  a_pre_mod: assert property (p_pre_mod) else $error("pre-modified address wrong"); // [RQ19]

  property p_acc_clear;
    @(posedge clock) disable iff (!resetn)
      (op_go && op_code == ACC_CLEAR_OP && !op_acc_b) |=> (accum_a == 40'h0 && acc_wb_valid_q);
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("clear did not zero accumulator"); // [RQ16]

  property p_clamp_a;
    @(posedge clock) disable iff (!resetn)
      (op_go && is_dsp && op_code != PREFETCH_STORE_OP && !op_acc_b && clamp_a
       && !clamp_wide) |=>
        (accum_a[39:31] == 9'h000 || accum_a[39:31] == 9'h1ff);
  endproperty
  a_clamp_a: assert property (p_clamp_a) else $error("accumulator a beyond narrow range"); // [RQ21]

  property p_pf_regs;
    @(posedge clock) disable iff (!resetn)
      (op_go && is_dsp) |=> (pf_x_reg_q[3:1] == 3'b100 && pf_y_reg_q[3:1] == 3'b101);
  endproperty
  a_pf_regs: assert property (p_pf_regs) else $error("prefetch pointer outside set"); // [RQ22]

endmodule : cad_datapath

// ### sim/cad_wreg_model.sv
// working register file model standing behind the result port
// assumes results arrive as one-cycle valid pulses on the core clock
module cad_wreg_model (
  input  wire logic        clock,
  input  wire logic        res_valid_q,
  input  wire logic        res_to_mem_q,
  input  wire logic [3:0]  res_wreg_lo_q,
  input  wire logic [3:0]  res_wreg_hi_q,
  input  wire logic [15:0] res_data_q,
  input  wire logic [15:0] res_hi_q,
  output logic      [15:0] wreg0,
  output logic      [15:0] wreg1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] wreg_q [16];
  // memory-bound results never touch the register file
  always @(posedge clock) begin
    if (res_valid_q && !res_to_mem_q) begin
      wreg_q[res_wreg_lo_q] <= res_data_q;
      wreg_q[res_wreg_hi_q] <= res_hi_q;
    end
  end
  assign wreg0 = wreg_q[0];
  assign wreg1 = wreg_q[1];
endmodule : cad_wreg_model

// ### sim/cad_datapath_tb.sv
// self-checking bench: register port, alu flags, multiply, divide, address unit
// assumes the model's register file holds the divide results
module cad_datapath_tb import cad_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, op_valid = 0, op_byte = 0;
  logic op_dst_mem = 0, div_signed = 0, div_long = 0, op_acc_b = 0;
  logic pf_x_sel = 0, pf_y_sel = 0, ea_valid = 0;
  logic [3:0] reg_addr = 0, op_dst_reg = 0;
  logic [4:0] op_lit = 0;
  logic [15:0] reg_wdata = 0, op_a = 0, op_b = 0, op_hi = 0, ea_ptr = 0, ea_offset = 0;
  logic [15:0] ea_lit = 0;
  cad_op_e op_code = OP_NOP;
  cad_mul_e mul_mode = MUL_SGN_SGN;
  cad_ea_e ea_mode = EA_INDIRECT;
  logic [15:0] reg_rdata, res_data_q, res_hi_q, acc_wb_data_q, ea_q, ea_ptr_new_q, wreg0, wreg1;
  logic op_ready, res_valid_q, res_to_mem_q, acc_wb_valid_q, ea_valid_q, ea_ptr_wr_q;
  logic [3:0] res_wreg_lo_q, res_wreg_hi_q, pf_x_reg_q, pf_y_reg_q;
  logic [4:0] core_flag_register;
  int n_mismatch = 0, check_count = 0, n;
  cad_datapath u_dut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .op_valid, .op_code, .op_byte, .op_dst_mem, .op_dst_reg, .mul_mode, .div_signed,
    .div_long, .op_a, .op_b, .op_hi, .op_lit, .op_acc_b, .pf_x_sel, .pf_y_sel, .op_ready,
    .res_valid_q, .res_data_q, .res_hi_q, .res_to_mem_q, .res_wreg_lo_q, .res_wreg_hi_q,
    .acc_wb_valid_q, .acc_wb_data_q, .pf_x_reg_q, .pf_y_reg_q, .core_flag_register,
    .ea_valid, .ea_mode, .ea_ptr, .ea_offset, .ea_lit, .ea_valid_q, .ea_q, .ea_ptr_new_q,
    .ea_ptr_wr_q);
  cad_wreg_model u_wreg (.clock, .res_valid_q, .res_to_mem_q, .res_wreg_lo_q,
    .res_wreg_hi_q, .res_data_q, .res_hi_q, .wreg0, .wreg1);
  always #4 clock = ~clock;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock) reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock) reg_wr <= 0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock) reg_rd <= 1;
    reg_addr <= a;
    @(posedge clock) reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task op(input cad_op_e c, input logic [15:0] a, input logic [15:0] b);
    @(posedge clock) op_valid <= 1;
    op_code <= c;
    op_a <= a;
    op_b <= b;
    @(posedge clock) op_valid <= 0;
    #1;
  endtask : op
  task ea(input cad_ea_e m, input logic [15:0] e);
    @(posedge clock) ea_valid <= 1;
    ea_mode <= m;
    @(posedge clock) ea_valid <= 0;
    #1 chk({ea_valid_q, ea_q}, {1'b1, e});
  endtask : ea
  task finish_test;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1;
    #1 chk({op_ready, pf_x_reg_q, pf_y_reg_q, core_flag_register}, {1'b1, 8'h8a, 5'h00});
    wr(4'h0, 16'h0055);
    rd(4'h0, 16'h0055);
    rd(4'hc, 16'h0000);
    op(OP_ADD, 16'h7fff, 16'h0001);
    chk({res_valid_q, res_data_q, core_flag_register}, {1'b1, 16'h8000, 5'h1c});
    op(OP_SUB, 16'h0005, 16'h0005);
    chk({res_data_q, core_flag_register}, {16'h0000, 5'h13});
    rd(4'h1, 16'h0013);
    @(posedge clock) op_byte <= 1;
    op(OP_ADD, 16'h12ff, 16'h0001);
    chk({res_data_q, core_flag_register[1:0]}, {16'h0000, 2'b11});
    @(posedge clock) op_byte <= 0;
    op(OP_MUL, 16'hffff, 16'h0002);
    chk({res_hi_q, res_data_q}, 32'hfffffffe);
    @(posedge clock) mul_mode <= MUL_UNS_UNS;
    op_dst_mem <= 1;
    op(OP_MUL, 16'hffff, 16'h0002);
    chk({res_hi_q, res_data_q}, 32'h0001fffe);
    chk(res_to_mem_q, 1'b1);
    @(posedge clock) op_dst_mem <= 0;
    div_signed <= 1;
    div_long <= 1;
    op_hi <= 16'h0000;
    op(OP_DIV, 16'h0064, 16'h0007);
    chk(op_ready, 1'b0);
    for (n = 1; n < 40 && res_valid_q !== 1'b1; n++) @(posedge clock) #1;
    if (n == 40) begin
      $display("MISMATCH %0t divide result timeout", $time);
      n_mismatch++;
      finish_test();
    end
    // sixteen steps, one finishing cycle, one result register
    chk(n, 18);
    chk({res_wreg_lo_q, res_wreg_hi_q}, 8'h01);
    @(posedge clock) #1 chk({wreg0, wreg1}, {16'd14, 16'd2});
    @(posedge clock) ea_ptr <= 16'h0100;
    ea_offset <= 16'h0020;
    ea_lit <= 16'h0004;
    ea(EA_INDIRECT, 16'h0100);
    chk(ea_ptr_wr_q, 1'b0);
    ea(EA_INDEXED, 16'h0120);
    ea(EA_LIT_OFFSET, 16'h0104);
    ea(EA_FILE_DIRECT, 16'h0004);
    ea(EA_REG_DIRECT, 16'h0100);
    ea(EA_POST_MOD, 16'h0100);
    chk({ea_ptr_wr_q, ea_ptr_new_q}, {1'b1, 16'h0104});
    ea(EA_PRE_MOD, 16'h0104);
    chk({ea_ptr_wr_q, ea_ptr_new_q}, {1'b1, 16'h0104});
    @(posedge clock) op_acc_b <= 1;
    pf_x_sel <= 1;
    op(OP_MAC, 16'h4000, 16'h4000);
    chk({acc_wb_valid_q, pf_x_reg_q, pf_y_reg_q}, {1'b1, 8'h9a});
    rd(4'h6, 16'h1000);
    @(posedge clock) op_acc_b <= 0;
    op(PRODUCT_LOAD_OP, 16'h0003, 16'hfffb);
    chk(acc_wb_valid_q, 1'b0);
    rd(4'h2, 16'hfff1);
    rd(4'h4, 16'h00ff);
    op(ACC_CLEAR_OP, 16'h0000, 16'h0000);
    // write back carries accumulator b rounded to its upper word
    chk({acc_wb_valid_q, acc_wb_data_q}, {1'b1, 16'h1000});
    rd(4'h2, 16'h0000);
    wr(4'h0, 16'h000d);
    repeat (3) op(OP_MAC, 16'h7fff, 16'h7fff);
    rd(4'h3, 16'h7fff);
    rd(4'h4, 16'h0000);
    finish_test();
  end
endmodule : cad_datapath_tb
